// ---- bench/pswv_host_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Bus host
// ----------------------------------------
module pswv_host_model (
	input wire logic clk_i,
	output logic txn_valid_o,
	output logic txn_write_o,
	output logic txn_word_o,
	output logic [7:0] txn_cmd_o,
	output logic [15:0] txn_wdata_o
);
	initial begin
		txn_valid_o = 1'b0;
		txn_write_o = 1'b0;
		txn_word_o = 1'b0;
		txn_cmd_o = 8'h00;
		txn_wdata_o = 16'h0000;
	end
	task automatic xfer(input logic wr, input logic word, input logic [7:0] cmd, input logic [15:0] data);
		@(posedge clk_i);
		txn_valid_o <= 1'b1;
		txn_write_o <= wr;
		txn_word_o <= word;
		txn_cmd_o <= cmd;
		txn_wdata_o <= data;
		@(posedge clk_i);
		txn_valid_o <= 1'b0;
		// Released command and data lines show the inverse so a stale value cannot pass for a live one.
		txn_cmd_o <= ~cmd;
		txn_wdata_o <= ~data;
	endtask
endmodule

// ---- bench/pswv_status_sva.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module pswv_status_sva #(
	parameter int OV_SRC_N = 3
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic txn_valid_i,
	input wire logic txn_write_i,
	input wire logic txn_word_i,
	input wire logic [7:0] txn_cmd_i,
	input wire logic [15:0] txn_wdata_i,
	input wire logic txn_hit_o,
	input wire logic rd_valid_o,
	input wire logic [OV_SRC_N-1:0] ov_fault_src_i,
	input wire logic clear_faults_i,
	input wire logic power_good_output_i,
	input wire logic unknown_flag_o,
	input wire logic [15:0] status_word_o,
	input wire logic [7:0] vout_flags_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic rd_take;
	logic clr7;
	logic vo_any;
	logic wd_wr;
	assign rd_take = txn_valid_i && !txn_write_i && txn_hit_o;
	assign wd_wr = txn_valid_i && txn_write_i && txn_word_i && txn_cmd_i == pswv_pkg::CMD_STATUS_WORD;
	assign clr7 = clear_faults_i || (txn_valid_i && txn_write_i && !txn_word_i
		&& txn_cmd_i == pswv_pkg::CMD_OUTPUT_VOLTAGE_FAULT_FLAGS && txn_wdata_i[7]);
	assign vo_any = |vout_flags_o;

	property p_rd_lat;
		rd_take |=> rd_valid_o;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer missing");
	property p_rd_none;
		!rd_take |=> !rd_valid_o;
	endproperty
	a_rd_none: assert property (p_rd_none) else $error("spurious read answer");
	property p_vo_zero;
		vout_flags_o[1:0] == 2'h0;
	endproperty
	a_vo_zero: assert property (p_vo_zero) else $error("unsupported flag bits set");
	property p_sw_zero;
		status_word_o[10] == 1'b0 && status_word_o[8] == 1'b0;
	endproperty
	a_sw_zero: assert property (p_sw_zero) else $error("unsupported word bits set");
	property p_sum;
		!$past(rst_i) |-> status_word_o[15] == $past(vo_any) && status_word_o[5] == $past(vout_flags_o[7]);
	endproperty
	a_sum: assert property (p_sum) else $error("summary bits disagree with flags");
	property p_pg;
		!$past(rst_i) |-> status_word_o[11] == $past(power_good_output_i);
	endproperty
	a_pg: assert property (p_pg) else $error("power good copy wrong");
	property p_ov_set;
		ov_fault_src_i != '0 |=> vout_flags_o[7];
	endproperty
	a_ov_set: assert property (p_ov_set) else $error("overvoltage flag not latched");
	property p_ov_hold;
		$fell(vout_flags_o[7]) |-> $past(clr7) || $past(rst_i);
	endproperty
	a_ov_hold: assert property (p_ov_hold) else $error("overvoltage flag lost");
	property p_busy_clr;
		wd_wr && txn_wdata_i == 16'h0080 |-> ##2 !status_word_o[7];
	endproperty
	a_busy_clr: assert property (p_busy_clr) else $error("busy not cleared");
	property p_unk;
		txn_valid_i && txn_cmd_i == pswv_pkg::CMD_STATUS_WORD && !txn_word_i |=> unknown_flag_o;
	endproperty
	a_unk: assert property (p_unk) else $error("unknown flag not set");
	property p_unk_clr;
		wd_wr && txn_wdata_i == 16'h0180 |=> !unknown_flag_o;
	endproperty
	a_unk_clr: assert property (p_unk_clr) else $error("unknown flag not cleared");
endmodule

bind pswv_status pswv_status_sva #(.OV_SRC_N(OV_SRC_N)) i_sva (.clk_i, .rst_i, .txn_valid_i, .txn_write_i,
	.txn_word_i, .txn_cmd_i, .txn_wdata_i, .txn_hit_o, .rd_valid_o, .ov_fault_src_i, .clear_faults_i,
	.power_good_output_i, .unknown_flag_o, .status_word_o, .vout_flags_o);

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Testbench
// ----------------------------------------
module testbench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic tv, tw, tword, hit, rdv, alert, unk;
	logic [7:0] tcmd, vf;
	logic [15:0] twd, rdd, sw;
	logic [4:0] ev = '0;
	logic [2:0] ovs = '0, xmask = '0;
	logic [9:0] live = '0;
	logic [7:0] vmask = '0;
	logic busy_ev = 1'b0, clr = 1'b0, bmask = 1'b0;
	logic [31:0] expq[$];
	logic [31:0] e;
	logic h;
	logic [15:0] lfsr_q = 16'h0053;
	int fails = 0, num_checks = 0, cyc = 0, i;
	always #25 clk_i = ~clk_i;
	pswv_host_model i_host (.clk_i(clk_i), .txn_valid_o(tv), .txn_write_o(tw), .txn_word_o(tword),
		.txn_cmd_o(tcmd), .txn_wdata_o(twd));
	pswv_status #(.OV_SRC_N(3)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .txn_valid_i(tv), .txn_write_i(tw),
		.txn_word_i(tword), .txn_cmd_i(tcmd), .txn_wdata_i(twd), .txn_hit_o(hit), .rd_valid_o(rdv),
		.rd_data_o(rdd), .ov_fault_src_i(ovs), .ov_warn_i(ev[4]), .uv_warn_i(ev[3]), .uv_fault_i(ev[2]),
		.vout_limit_i(ev[1]), .ton_max_i(ev[0]), .busy_event_i(busy_ev), .clear_faults_i(clr),
		.iout_any_i(live[0]), .iout_oc_i(live[1]), .input_any_i(live[2]), .vin_uv_i(live[3]),
		.mfr_any_i(live[4]), .other_any_i(live[5]), .temp_any_i(live[6]), .cml_any_i(live[7]),
		.unit_off_i(live[8]), .power_good_output_i(live[9]), .vout_alert_mask_i(vmask),
		.busy_alert_mask_i(bmask), .extended_alert_mask_i(xmask), .alert_o(alert),
		.unknown_flag_o(unk), .status_word_o(sw), .vout_flags_o(vf));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic rd(input logic [7:0] cmd, input logic word, input logic [15:0] exp, input logic [15:0] m);
		expq.push_back({m, exp});
		i_host.xfer(1'b0, word, cmd, 16'h0000);
	endtask
	// Bit 0 folds in terms whose exact mix is open, so it is only checked where it must be one.
	task automatic rdw(input logic [7:0] f, input logic b);
		logic k;
		k = live[4] | live[5] | (|f[6:2]);
		rd(pswv_pkg::CMD_STATUS_WORD, 1'b1, {|f, live[0], live[2], live[4], live[9], 1'b0, live[5], 1'b0,
			b, live[8], f[7], live[1], live[3], live[6], live[7], k}, {15'h7FFF, k});
	endtask
	task automatic fire(input logic [4:0] x, input logic [2:0] s, input logic b, input logic c);
		@(posedge clk_i);
		ev <= x;
		ovs <= s;
		busy_ev <= b;
		clr <= c;
		@(posedge clk_i);
		ev <= '0;
		ovs <= '0;
		busy_ev <= 1'b0;
		clr <= 1'b0;
	endtask
	task automatic settle;
		repeat (3) @(posedge clk_i);
	endtask
	always @(posedge clk_i) begin
		if (rdv === 1'b1) begin
			if (expq.size() == 0)
				chk(rdd, 16'hFFFF ^ rdd);
			else begin
				e = expq.pop_front();
				chk(rdd & e[31:16], e[15:0] & e[31:16]);
			end
		end
		// A request is taken only at our codes with the matching access size.
		if (tv === 1'b1) begin
			h = (tcmd == pswv_pkg::CMD_STATUS_WORD) ? tword
				: (!tword && (tcmd == pswv_pkg::CMD_STATUS_BYTE || tcmd == pswv_pkg::CMD_OUTPUT_VOLTAGE_FAULT_FLAGS));
			chk(16'(hit), 16'(h));
		end
		cyc++;
		if (cyc > 3000) begin
			fails++;
			summarize();
		end
	end
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rdw(8'h00, 1'b0);
		rd(pswv_pkg::CMD_OUTPUT_VOLTAGE_FAULT_FLAGS, 1'b0, 16'h0000, 16'hFFFF);
		rd(pswv_pkg::CMD_STATUS_BYTE, 1'b0, 16'h0000, 16'hFFFF);
		i_host.xfer(1'b0, 1'b0, 8'h7B, 16'h0000);
		i_host.xfer(1'b0, 1'b1, pswv_pkg::CMD_OUTPUT_VOLTAGE_FAULT_FLAGS, 16'h0000);
		settle();
		chk(16'(unk), 16'h0001);
		$display("reset values done");
		for (i = 0; i < 5; i++) begin
			fire(5'(1 << i), 3'h0, 1'b0, 1'b0);
			i_host.xfer(1'b1, 1'b0, pswv_pkg::CMD_OUTPUT_VOLTAGE_FAULT_FLAGS, 16'h0003);
			rd(pswv_pkg::CMD_OUTPUT_VOLTAGE_FAULT_FLAGS, 1'b0, 16'(4 << i), 16'hFFFF);
			rdw(8'(4 << i), 1'b0);
			i_host.xfer(1'b1, 1'b0, pswv_pkg::CMD_OUTPUT_VOLTAGE_FAULT_FLAGS, 16'(4 << i));
			rd(pswv_pkg::CMD_OUTPUT_VOLTAGE_FAULT_FLAGS, 1'b0, 16'h0000, 16'hFFFF);
		end
		$display("voltage flags done");
		xmask <= 3'h1;
		fire(5'h00, 3'h1, 1'b0, 1'b0);
		settle();
		chk(16'(alert), 16'h0000);
		fire(5'h00, 3'h2, 1'b0, 1'b0);
		settle();
		chk(16'(alert), 16'h0001);
		vmask <= 8'h80;
		settle();
		chk(16'(alert), 16'h0000);
		i_host.xfer(1'b1, 1'b1, pswv_pkg::CMD_STATUS_WORD, 16'hFF00);
		rdw(8'h80, 1'b0);
		fire(5'h00, 3'h0, 1'b0, 1'b1);
		rd(pswv_pkg::CMD_OUTPUT_VOLTAGE_FAULT_FLAGS, 1'b0, 16'h0000, 16'hFFFF);
		$display("overvoltage done");
		fire(5'h00, 3'h0, 1'b1, 1'b0);
		settle();
		chk(16'(alert), 16'h0001);
		bmask <= 1'b1;
		settle();
		chk(16'(alert), 16'h0000);
		bmask <= 1'b0;
		rd(pswv_pkg::CMD_STATUS_BYTE, 1'b0, 16'h0080, 16'hFFFF);
		i_host.xfer(1'b1, 1'b0, pswv_pkg::CMD_STATUS_BYTE, 16'h0080);
		rdw(8'h00, 1'b0);
		fire(5'h00, 3'h0, 1'b1, 1'b0);
		i_host.xfer(1'b0, 1'b0, pswv_pkg::CMD_STATUS_WORD, 16'h0000);
		i_host.xfer(1'b1, 1'b1, pswv_pkg::CMD_STATUS_WORD, 16'h0080);
		settle();
		chk(16'(unk), 16'h0001);
		rdw(8'h00, 1'b0);
		fire(5'h00, 3'h0, 1'b1, 1'b0);
		i_host.xfer(1'b1, 1'b1, pswv_pkg::CMD_STATUS_WORD, 16'h0180);
		settle();
		chk(16'(unk), 16'h0000);
		rdw(8'h00, 1'b0);
		$display("busy and unknown done");
		for (i = 0; i < 8; i++) begin
			@(posedge clk_i);
			lfsr_q <= lfsr_next(lfsr_q);
			live <= lfsr_q[9:0];
			@(negedge clk_i);
			rdw(8'h00, 1'b0);
		end
		settle();
		chk(16'(expq.size()), 16'h0000);
		$display("live bits done");
		summarize();
	end
endmodule

// ---- design/pswv_alert_gate.sv ----
`timescale 1ns/1ps
module pswv_alert_gate #(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] flags_i,
	input wire logic [W-1:0] mask_i,
	output logic alert_o
);

	generate
		if (W < 1) begin : g_bad_param
			$error("W must be at least 1");
		end
	endgenerate

	logic alert_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			alert_q <= 1'b0;
		end else begin
			alert_q <= |(flags_i & ~mask_i);
		end
	end

	assign alert_o = alert_q;

endmodule

// ---- design/pswv_flag_bank.sv ----
`timescale 1ns/1ps
module pswv_flag_bank #(
	parameter int W = 8,
	parameter logic [W-1:0] IMPL = '1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] set_i,
	input wire logic [W-1:0] clr_i,
	output logic [W-1:0] flags_o
);

	generate
		if (W < 1) begin : g_bad_param
			$error("W must be at least 1");
		end
	endgenerate

	logic [W-1:0] flags_q;
	logic [W-1:0] flags_d;

	// Set wins over clear so an event arriving during a clear is kept.
	always_comb begin
		flags_d = ((flags_q & ~clr_i) | set_i) & IMPL;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_q <= '0;
		end else begin
			flags_q <= flags_d;
		end
	end

	assign flags_o = flags_q;

endmodule

// ---- design/pswv_pkg.sv ----
package pswv_pkg;

	// ---------------------------------------------------------------
	// Command codes
	// ---------------------------------------------------------------
	localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
	localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
	localparam logic [7:0] CMD_OUTPUT_VOLTAGE_FAULT_FLAGS = 8'h7A;

	// ---------------------------------------------------------------
	// Fault summary word, upper byte
	// ---------------------------------------------------------------
	localparam int SW_VOUT = 15;
	localparam int SW_IOUT = 14;
	localparam int SW_INPUT = 13;
	localparam int SW_MFR = 12;
	localparam int SW_PWR_GOOD = 11;
	localparam int SW_RSVD10 = 10;
	localparam int SW_OTHER = 9;
	localparam int SW_UNKNOWN_CLR = 8;

	// ---------------------------------------------------------------
	// Fault summary word, low byte (shared status byte)
	// ---------------------------------------------------------------
	localparam int SB_BUSY = 7;
	localparam int SB_OFF = 6;
	localparam int SB_VOUT_OV = 5;
	localparam int SB_IOUT_OC = 4;
	localparam int SB_VIN_UV = 3;
	localparam int SB_TEMP = 2;
	localparam int SB_CML = 1;
	localparam int SB_NOTA = 0;

	// ---------------------------------------------------------------
	// Output voltage fault flags
	// ---------------------------------------------------------------
	localparam int VO_OVF = 7;
	localparam int VO_OVW = 6;
	localparam int VO_UVW = 5;
	localparam int VO_UVF = 4;
	localparam int VO_MINMAX = 3;
	localparam int VO_TONMAX = 2;
	localparam logic [7:0] VO_IMPL = 8'hFC;
	localparam logic [7:0] VO_RESET = 8'h00;
	localparam logic [15:0] SW_RESET = 16'h0000;

	// ---------------------------------------------------------------
	// Decoded access kinds
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		PSWV_ACC_NONE,
		PSWV_ACC_READ,
		PSWV_ACC_WR_BYTE,
		PSWV_ACC_WR_WORD,
		PSWV_ACC_WR_VOUT,
		PSWV_ACC_BAD
	} pswv_acc_t;

endpackage

// ---- design/pswv_status.sv ----
// Function
// [RL1] Fault summary word answers at 79h, word access
// [RL2] Low byte is the shared status byte
// [RL3] Bit 15 shows output voltage fault summary
// [RL4] Bit 14 shows output current fault summary
// [RL5] Bit 13 shows input fault summary
// [RL6] Bit 12 shows manufacturer fault summary
// [RL7] Bit 11 is live power-good copy
// [RL8] Bit 9 shows other fault summary
// [RL9] Bits 10 and 8 read zero
// [RL10] Writing 0080h clears busy flag
// [RL11] Writing 0180h clears busy and unknown flags
// [RL12] Each alerting status bit has mask bit
// [RL13] Voltage fault flags answer at 7Ah, byte access
// [RL14] Write one clears flag, clear-all clears all
// [RL15] Bit 7 latches output overvoltage fault
// [RL16] Overvoltage mask covers three sources, extended per-source
// [RL17] Bit 6 latches output overvoltage warning
// [RL18] Bit 5 latches output undervoltage warning
// [RL19] Bit 4 latches output undervoltage fault
// [RL20] Bits 3,2 latch limit and turn-on timeout
// [RL21] Voltage flag bits 1,0 read zero
// [RL22] Busy flag set when too busy
// [RL23] Summary bits are OR of detailed flags
// [RL24] Writes to upper summary byte ignored
`timescale 1ns/1ps
module pswv_status #(
	parameter int OV_SRC_N = 3
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// Command port.
	input wire logic txn_valid_i,
	input wire logic txn_write_i,
	input wire logic txn_word_i,
	input wire logic [7:0] txn_cmd_i,
	input wire logic [15:0] txn_wdata_i,
	output logic txn_hit_o,
	output logic rd_valid_o,
	output logic [15:0] rd_data_o,
	// Events from fault detection.
	input wire logic [OV_SRC_N-1:0] ov_fault_src_i,
	input wire logic ov_warn_i,
	input wire logic uv_warn_i,
	input wire logic uv_fault_i,
	input wire logic vout_limit_i,
	input wire logic ton_max_i,
	input wire logic busy_event_i,
	input wire logic clear_faults_i,
	// Summaries of the other status registers and live states.
	input wire logic iout_any_i,
	input wire logic iout_oc_i,
	input wire logic input_any_i,
	input wire logic vin_uv_i,
	input wire logic mfr_any_i,
	input wire logic other_any_i,
	input wire logic temp_any_i,
	input wire logic cml_any_i,
	input wire logic unit_off_i,
	input wire logic power_good_output_i,
	// Alert masks.
	input wire logic [7:0] vout_alert_mask_i,
	input wire logic busy_alert_mask_i,
	input wire logic [OV_SRC_N-1:0] extended_alert_mask_i,
	output logic alert_o,
	output logic unknown_flag_o,
	output logic [15:0] status_word_o,
	output logic [7:0] vout_flags_o
);

	// ---------------------------------------------------------------
	// Parameter check
	// ---------------------------------------------------------------
	generate
		if (OV_SRC_N < 1 || OV_SRC_N > 8) begin : g_bad_param
			$error("OV_SRC_N must lie between 1 and 8");
		end
	endgenerate

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	// Access size is part of the command: a byte access to the word
	// command, or a word access to a byte command, is refused.
	function automatic pswv_pkg::pswv_acc_t decode(
		input logic valid,
		input logic wr,
		input logic word,
		input logic [7:0] cmd
	);
		pswv_pkg::pswv_acc_t k;
		k = pswv_pkg::PSWV_ACC_NONE;
		if (valid) begin
			case (cmd)
				pswv_pkg::CMD_STATUS_BYTE: begin
					if (word) begin
						k = pswv_pkg::PSWV_ACC_BAD;
					end else begin
						k = wr ? pswv_pkg::PSWV_ACC_WR_BYTE : pswv_pkg::PSWV_ACC_READ;
					end
				end
				pswv_pkg::CMD_STATUS_WORD: begin
					if (!word) begin
						k = pswv_pkg::PSWV_ACC_BAD;
					end else begin
						k = wr ? pswv_pkg::PSWV_ACC_WR_WORD : pswv_pkg::PSWV_ACC_READ;
					end
				end
				pswv_pkg::CMD_OUTPUT_VOLTAGE_FAULT_FLAGS: begin
					if (word) begin
						k = pswv_pkg::PSWV_ACC_BAD;
					end else begin
						k = wr ? pswv_pkg::PSWV_ACC_WR_VOUT : pswv_pkg::PSWV_ACC_READ;
					end
				end
				default: begin
					k = pswv_pkg::PSWV_ACC_NONE;
				end
			endcase
		end
		return k;
	endfunction

	pswv_pkg::pswv_acc_t acc;

	always_comb begin
		acc = decode(txn_valid_i, txn_write_i, txn_word_i, txn_cmd_i);
	end

	// A hit means the access is ours and of the right size.
	assign txn_hit_o = (acc != pswv_pkg::PSWV_ACC_NONE) && (acc != pswv_pkg::PSWV_ACC_BAD);

	// ---------------------------------------------------------------
	// Output voltage fault flags
	// ---------------------------------------------------------------
	logic [7:0] vout_set;
	logic [7:0] vout_clr;
	logic [7:0] vout_flags;

	always_comb begin
		vout_set = '0;
		vout_set[pswv_pkg::VO_OVF] = |ov_fault_src_i; // RL15
		vout_set[pswv_pkg::VO_OVW] = ov_warn_i; // RL17
		vout_set[pswv_pkg::VO_UVW] = uv_warn_i; // RL18
		vout_set[pswv_pkg::VO_UVF] = uv_fault_i; // RL19
		vout_set[pswv_pkg::VO_MINMAX] = vout_limit_i; // RL20
		vout_set[pswv_pkg::VO_TONMAX] = ton_max_i; // RL20
	end

	always_comb begin
		vout_clr = '0;
		if (clear_faults_i) begin
			vout_clr = '1; // RL14
		end else if (acc == pswv_pkg::PSWV_ACC_WR_VOUT) begin
			vout_clr = txn_wdata_i[7:0]; // RL14
		end
	end

	// Unsupported bits are held at zero by the implemented-bit mask.
	pswv_flag_bank #(
		.W(8),
		.IMPL(pswv_pkg::VO_IMPL)
	) u_vout_flags (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.set_i(vout_set),
		.clr_i(vout_clr),
		.flags_o(vout_flags)
	); // RL21

	// ---------------------------------------------------------------
	// Overvoltage source record
	// ---------------------------------------------------------------
	// Which sources raised the overvoltage flag is remembered so the
	// extended mask can gate each on its own; it follows the flag's clear.
	logic [OV_SRC_N-1:0] ov_src_q;
	logic ov_clr;

	assign ov_clr = vout_clr[pswv_pkg::VO_OVF];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ov_src_q <= '0;
		end else begin
			ov_src_q <= (ov_src_q & {OV_SRC_N{~ov_clr}}) | ov_fault_src_i; // RL16
		end
	end

	// ---------------------------------------------------------------
	// Busy and unknown flags
	// ---------------------------------------------------------------
	logic busy_q;
	logic unknown_q;
	logic busy_clr;
	logic unknown_clr;
	logic unknown_set;

	// A set data bit clears the flag; writing zero leaves it alone.
	always_comb begin
		busy_clr = 1'b0;
		unknown_clr = 1'b0;
		if (clear_faults_i) begin
			busy_clr = 1'b1;
			unknown_clr = 1'b1;
		end else if (acc == pswv_pkg::PSWV_ACC_WR_WORD) begin
			busy_clr = txn_wdata_i[pswv_pkg::SB_BUSY]; // RL10
			unknown_clr = txn_wdata_i[pswv_pkg::SW_UNKNOWN_CLR]; // RL11
		end else if (acc == pswv_pkg::PSWV_ACC_WR_BYTE) begin
			busy_clr = txn_wdata_i[pswv_pkg::SB_BUSY]; // RL2
		end
	end

	assign unknown_set = (acc == pswv_pkg::PSWV_ACC_BAD);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_q <= 1'b0;
		end else if (busy_event_i) begin
			busy_q <= 1'b1; // RL22
		end else if (busy_clr) begin
			busy_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			unknown_q <= 1'b0;
		end else if (unknown_set) begin
			unknown_q <= 1'b1;
		end else if (unknown_clr) begin
			unknown_q <= 1'b0; // RL11
		end
	end

	// ---------------------------------------------------------------
	// Summary word assembly
	// ---------------------------------------------------------------
	// The word is formed from the flags every cycle, so there is no
	// separate upper-byte storage that a write could touch.
	logic [15:0] word_d;
	logic vout_any;

	assign vout_any = |vout_flags; // RL23

	always_comb begin
		word_d = pswv_pkg::SW_RESET;
		word_d[pswv_pkg::SW_VOUT] = vout_any; // RL3
		word_d[pswv_pkg::SW_IOUT] = iout_any_i; // RL4
		word_d[pswv_pkg::SW_INPUT] = input_any_i; // RL5
		word_d[pswv_pkg::SW_MFR] = mfr_any_i; // RL6
		word_d[pswv_pkg::SW_PWR_GOOD] = power_good_output_i; // RL7
		word_d[pswv_pkg::SW_RSVD10] = 1'b0; // RL9
		word_d[pswv_pkg::SW_OTHER] = other_any_i; // RL8
		word_d[pswv_pkg::SW_UNKNOWN_CLR] = 1'b0; // RL9
		word_d[pswv_pkg::SB_BUSY] = busy_q; // RL2
		word_d[pswv_pkg::SB_OFF] = unit_off_i;
		word_d[pswv_pkg::SB_VOUT_OV] = vout_flags[pswv_pkg::VO_OVF]; // RL23
		word_d[pswv_pkg::SB_IOUT_OC] = iout_oc_i;
		word_d[pswv_pkg::SB_VIN_UV] = vin_uv_i;
		word_d[pswv_pkg::SB_TEMP] = temp_any_i;
		word_d[pswv_pkg::SB_CML] = cml_any_i;
		word_d[pswv_pkg::SB_NOTA] = (vout_any & ~vout_flags[pswv_pkg::VO_OVF])
			| (iout_any_i & ~iout_oc_i) | (input_any_i & ~vin_uv_i)
			| mfr_any_i | other_any_i;
	end

	logic [15:0] word_q;

	// Writes never land here: the upper byte is read-only.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			word_q <= pswv_pkg::SW_RESET;
		end else begin
			word_q <= word_d; // RL24
		end
	end

	assign status_word_o = word_q;
	assign vout_flags_o = vout_flags;
	assign unknown_flag_o = unknown_q;

	// ---------------------------------------------------------------
	// Read answers
	// ---------------------------------------------------------------
	logic rd_valid_q;
	logic [15:0] rd_data_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= (acc == pswv_pkg::PSWV_ACC_READ);
		end
	end

	// Byte reads sit in the low bits with the upper byte at zero.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_data_q <= '0;
		end else if (acc == pswv_pkg::PSWV_ACC_READ) begin
			case (txn_cmd_i)
				pswv_pkg::CMD_STATUS_WORD: begin
					rd_data_q <= word_d; // RL1
				end
				pswv_pkg::CMD_STATUS_BYTE: begin
					rd_data_q <= {8'h00, word_d[7:0]}; // RL2
				end
				pswv_pkg::CMD_OUTPUT_VOLTAGE_FAULT_FLAGS: begin
					rd_data_q <= {8'h00, vout_flags}; // RL13
				end
				default: begin
					rd_data_q <= '0;
				end
			endcase
		end
	end

	assign rd_valid_o = rd_valid_q;
	assign rd_data_o = rd_data_q;

	// ---------------------------------------------------------------
	// Alert gating
	// ---------------------------------------------------------------
	// The overvoltage flag alerts only through an unmasked source that
	// raised it; its own mask bit still silences all sources together.
	logic [8:0] alert_flags;
	logic [8:0] alert_mask;
	logic ov_alert_src;

	assign ov_alert_src = |(ov_src_q & ~extended_alert_mask_i); // RL16

	always_comb begin
		alert_flags = {busy_q, vout_flags};
		alert_flags[pswv_pkg::VO_OVF] = vout_flags[pswv_pkg::VO_OVF] & ov_alert_src;
		alert_mask = {busy_alert_mask_i, vout_alert_mask_i}; // RL12
	end

	pswv_alert_gate #(
		.W(9)
	) u_alert (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.flags_i(alert_flags),
		.mask_i(alert_mask),
		.alert_o(alert_o)
	); // RL12

endmodule
